/* include/acpc_pkg.sv */
// package: constants and types for converter conversion/power control
package acpc_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 20;
  // conversion time, typical figure in ns
  localparam int unsigned CONV_TIME_NS    = 500;
  localparam int unsigned CONV_CYCLES     =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 8;
  localparam logic [CNT_W-1:0] CONV_CNT_LAST =
    CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE    = 8'h01;
  // global reset pulse length, cycles
  localparam int unsigned GRST_CYCLES     = 4;
  localparam logic [CNT_W-1:0] GRST_CNT_LAST =
    CNT_W'(GRST_CYCLES - 1);

  typedef enum logic [1:0] {
    ACPC_ST_IDLE,
    ACPC_ST_CONV,
    ACPC_ST_PDOWN,
    ACPC_ST_GRST
  } acpc_state_e;

  // synchronised pin levels
  typedef struct packed {
    logic conv_start;
    logic power_down;
    logic io_mode;
  } acpc_pins_s;

endpackage : acpc_pkg

/* rtl/acpc_sync.sv */
// two-stage synchroniser for asynchronous pin levels
module acpc_sync
  import acpc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             arst_n_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage read only by the second
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : acpc_sync

/* rtl/acpc_ctrl.sv */
// conversion start, busy and power-down control of the converter
module acpc_ctrl
  import acpc_pkg::*;
(
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic arst_n_in,
  // pins from controller
  input  wire logic conversion_start_in,
  input  wire logic power_down_in,
  input  wire logic io_mode_sel_in,
  // status to controller and core
  output logic      busy_out,
  output logic      hold_out,
  output logic      powered_down_out,
  output logic      global_reset_out,
  output logic      diff_io_mode_out
);

  acpc_pins_s  pins;
  acpc_state_e state_reg;
  acpc_state_e state_next;
  logic [CNT_W-1:0] conv_cnt_reg;
  logic [CNT_W-1:0] grst_cnt_reg;
  logic        busy_next;
  logic        pdn_next;
  logic        grst_next;
  logic        conv_prev_reg;
  logic        pd_prev_reg;
  logic        pd_seen_reg;
  logic        conv_edge;
  logic        pd_edge;
  logic        conv_done;
  logic        grst_done;
  logic        grst_req;

  // pins are asynchronous to the core clock
  acpc_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .async_in    ({conversion_start_in, power_down_in, io_mode_sel_in}),
    .sync_out    (pins)
  );

  // previous start level; reset low like the idle pin, so no false edge
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      conv_prev_reg <= 1'b0;
    else
      conv_prev_reg <= pins.conv_start;
  end

  // previous power-down level for its rise detector
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pd_prev_reg <= 1'b0;
    else
      pd_prev_reg <= pins.power_down;
  end

  // chip select is not an input here at all
  assign conv_edge = pins.conv_start & ~conv_prev_reg;
  assign pd_edge   = pins.power_down & ~pd_prev_reg;
  assign conv_done = (state_reg == ACPC_ST_CONV) &&
                     (conv_cnt_reg == CONV_CNT_LAST);
  assign grst_done = (state_reg == ACPC_ST_GRST) &&
                     (grst_cnt_reg == GRST_CNT_LAST);
  // second rise without an intervening conversion
  assign grst_req  = pd_edge & pd_seen_reg;

  // tracks power-down rises since the last conversion
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      pd_seen_reg <= 1'b0;
    else if (grst_req || grst_done)
      pd_seen_reg <= 1'b0;
    else if (pd_edge)
      pd_seen_reg <= 1'b1;
    else if (state_reg == ACPC_ST_CONV)
      pd_seen_reg <= 1'b0;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ACPC_ST_IDLE:
      begin
        if (grst_req)
          state_next = ACPC_ST_GRST;
        else if (pins.power_down)
          state_next = ACPC_ST_PDOWN;
        else if (conv_edge)
          state_next = ACPC_ST_CONV;
      end
      ACPC_ST_CONV:
      begin
        // power-down waits for the conversion to end
        if (conv_done)
          state_next = pins.power_down ? ACPC_ST_PDOWN : ACPC_ST_IDLE;
      end
      ACPC_ST_PDOWN:
      begin
        // start edges ignored while powered down
        if (grst_req)
          state_next = ACPC_ST_GRST;
        else if (!pins.power_down)
          state_next = ACPC_ST_IDLE;
      end
      ACPC_ST_GRST:
      begin
        if (grst_done)
          state_next = pins.power_down ? ACPC_ST_PDOWN : ACPC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_reg <= ACPC_ST_IDLE;
    else
      state_reg <= state_next;
  end

  // conversion timer; zero outside a conversion, typical time only
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      conv_cnt_reg <= CNT_ZERO;
    else if (state_reg != ACPC_ST_CONV)
      conv_cnt_reg <= CNT_ZERO;
    else
      conv_cnt_reg <= conv_cnt_reg + CNT_ONE;
  end

  // reset pulse timer, kept apart so neither phase disturbs the other
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      grst_cnt_reg <= CNT_ZERO;
    else if (state_reg != ACPC_ST_GRST)
      grst_cnt_reg <= CNT_ZERO;
    else
      grst_cnt_reg <= grst_cnt_reg + CNT_ONE;
  end

  // outputs follow the next state so they align with it
  always_comb
  begin
    busy_next = (state_next == ACPC_ST_CONV);
    pdn_next  = (state_next == ACPC_ST_PDOWN);
    grst_next = (state_next == ACPC_ST_GRST);
  end

  // busy straight from a flop, no glitch on the pin
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      busy_out <= 1'b0;
    else
      busy_out <= busy_next;
  end

  // hold spans exactly the conversion
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      hold_out <= 1'b0;
    else
      hold_out <= busy_next;
  end

  // powered down, deferred while a conversion runs
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      powered_down_out <= 1'b0;
    else
      powered_down_out <= pdn_next;
  end

  // reset pulse; other core logic resets outside this block
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      global_reset_out <= 1'b0;
    else
      global_reset_out <= grst_next;
  end

  // strap is static; sampled continuously after reset release
  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      diff_io_mode_out <= 1'b0;
    else
      diff_io_mode_out <= pins.io_mode;
  end

endmodule : acpc_ctrl

/* tb/acpc_ctrl_assertions.sv */
// port assertions for conversion and power-down control
module acpc_ctrl_checker
(
  // clock, reset, pins
  input wire logic core_clk_in,
  input wire logic arst_n_in,
  input wire logic conversion_start_in,
  input wire logic power_down_in,
  input wire logic io_mode_sel_in,
  // status
  input wire logic busy_out,
  input wire logic hold_out,
  input wire logic powered_down_out,
  input wire logic global_reset_out,
  input wire logic diff_io_mode_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  hold_busy_a: assert property (hold_out == busy_out)
    else $error("hold");
  start_conv_a: assert property (
    $rose(conversion_start_in) && !busy_out && !powered_down_out
    && !global_reset_out && !power_down_in |-> ##3 busy_out)
    else $error("start");
  busy_len_a: assert property (
    $rose(busy_out) |-> ##24 busy_out ##1 !busy_out)
    else $error("busy");
  pd_enter_a: assert property (
    $rose(power_down_in) && !busy_out && !powered_down_out
    && !global_reset_out |-> ##3 (powered_down_out || global_reset_out))
    else $error("pd");
  pd_defer_a: assert property (
    $fell(busy_out) && power_down_in && $past(power_down_in, 3)
    |-> powered_down_out && !$past(powered_down_out))
    else $error("defer");
  grst_len_a: assert property (
    $rose(global_reset_out) |-> global_reset_out[*4] ##1 !global_reset_out)
    else $error("grst");
  io_mode_a: assert property (
    $stable(io_mode_sel_in)[*4] |-> diff_io_mode_out == io_mode_sel_in)
    else $error("mode");
endmodule : acpc_ctrl_checker

bind acpc_ctrl acpc_ctrl_checker u_acpc_ctrl_checker (
  .core_clk_in         (core_clk_in),
  .arst_n_in           (arst_n_in),
  .conversion_start_in (conversion_start_in),
  .power_down_in       (power_down_in),
  .io_mode_sel_in      (io_mode_sel_in),
  .busy_out            (busy_out),
  .hold_out            (hold_out),
  .powered_down_out    (powered_down_out),
  .global_reset_out    (global_reset_out),
  .diff_io_mode_out    (diff_io_mode_out)
);

/* tb/acpc_host_model.sv */
// controller model driving start and power-down pins
module acpc_host_model
(
  // clock and status
  input  wire logic clk_in,
  input  wire logic busy_in,
  // pins
  output logic      start_out,
  output logic      pd_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    start_out = 1'b0;
    pd_out    = 1'b0;
  end
  // early lets a scenario break the wait on purpose
  task automatic start_conv(input bit early);
    while (!early && busy_in === 1'b1) @(negedge clk_in);
    @(negedge clk_in);
    start_out = 1'b1;
    repeat (3) @(negedge clk_in);
    start_out = 1'b0;
  endtask : start_conv
  task automatic set_pd(input logic v);
    @(negedge clk_in);
    pd_out = v;
  endtask : set_pd
endmodule : acpc_host_model

/* tb/acpc_ctrl_bench.sv */
// bench for conversion and power-down control
module acpc_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, mode = 0, st, pd, busy, hold, pdn, grst, diff;
  int   bad_count = 0, check_count = 0, cyc = 0, n;
  initial forever #10 clk = ~clk;
  acpc_host_model u_acpc_host_model (.clk_in(clk), .busy_in(busy),
    .start_out(st), .pd_out(pd));
  acpc_ctrl u_acpc_ctrl (.core_clk_in(clk), .arst_n_in(rst_n),
    .conversion_start_in(st), .power_down_in(pd), .io_mode_sel_in(mode),
    .busy_out(busy), .hold_out(hold), .powered_down_out(pdn),
    .global_reset_out(grst), .diff_io_mode_out(diff));
  task automatic chk(input logic [7:0] s, e);
    check_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask : chk
  task automatic wc(input int k);
    repeat (k) @(negedge clk);
  endtask : wc
  task automatic run;
    n = 0;
    while (busy === 1'b1 && n < 99)
    begin
      n++;
      wc(1);
    end
  endtask : run
  // dbl fires a second start while busy
  task automatic t_conv(input bit dbl);
    u_acpc_host_model.start_conv(1'b0);
    wc(1);
    chk({busy, hold}, 2'b11);
    if (dbl)
      u_acpc_host_model.start_conv(1'b1);
    run();
    // run starts one (or five, after the extra pulse) cycles into busy
    chk(8'(n), dbl ? 8'(acpc_pkg::CONV_CYCLES - 5)
                   : 8'(acpc_pkg::CONV_CYCLES - 1));
    wc(6);
    chk(busy, 1'b0);
  endtask : t_conv
  task automatic t_pd;
    u_acpc_host_model.set_pd(1'b1);
    wc(4);
    chk({pdn, grst}, 2'b10);
    u_acpc_host_model.start_conv(1'b0);
    wc(4);
    chk(busy, 1'b0);
    u_acpc_host_model.set_pd(1'b0);
    wc(5);
  endtask : t_pd
  task automatic t_defer;
    u_acpc_host_model.start_conv(1'b0);
    u_acpc_host_model.set_pd(1'b1);
    wc(8);
    chk({busy, pdn}, 2'b10);
    run();
    chk(pdn, 1'b1);
    u_acpc_host_model.set_pd(1'b0);
    wc(6);
  endtask : t_defer
  task automatic t_grst;
    t_pd();
    u_acpc_host_model.set_pd(1'b1);
    n = 0;
    while (grst !== 1'b1 && n < 9)
    begin
      n++;
      wc(1);
    end
    chk(grst, 1'b1);
    wc(8);
    chk({pdn, grst}, 2'b10);
    u_acpc_host_model.set_pd(1'b0);
    wc(6);
  endtask : t_grst
  task automatic t_mode(input logic v);
    mode = v;
    wc(5);
    chk(diff, v);
  endtask : t_mode
  task automatic test_done;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count++;
      test_done();
    end
  end
  initial
  begin
    wc(3);
    rst_n = 1'b1;
    wc(2);
    t_conv(1'b0);
    t_conv(1'b1);
    t_pd();
    t_conv(1'b0);
    t_defer();
    t_conv(1'b0);
    t_grst();
    t_mode(1'b1);
    t_mode(1'b0);
    test_done();
  end
endmodule : acpc_ctrl_bench
